// >>> logic/scs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
// Function
// - shift input bit on each rising clock
// - capture only while select low
// - readback pin low during address part
// - readback bit changes on falling clock
// - reads ignore input data, change nothing
// - pin keeps driving until enable cleared
// - readback shows live internal state
// - pin can show multiplier lock status
module scs_top (
  input  wire logic        mclk_in,                  // system clock, 50 MHz
  input  wire logic        resetn_in,                // async reset, active low
  input  wire logic        sclk_pin_in,              // serial clock from host
  input  wire logic        cs_pin_n_in,              // chip select, active low
  input  wire logic        serial_in_pin_in,         // serial data from host
  input  wire logic        lock_status_in,           // multiplier lock level
  input  wire logic [15:0] live_status_in,           // live device state levels
  output logic             readback_mux_pin_out,     // readback pin level
  output logic             readback_mux_pin_oe_out,  // readback pin drive enable
  output logic [15:0]      cfg_word_out              // current configuration word
);
  localparam int SYNC_W = 20;

  logic [SYNC_W-1:0]    pin_meta_q;
  logic [SYNC_W-1:0]    pin_sync_q;
  logic                 sclk_prev_q;
  logic                 cs_n_prev_q;
  logic [4:0]           bit_cnt_q;
  logic [4:0]           bit_cnt_d;
  logic [23:0]          shift_q;
  scs_pkg::scs_addr_t   addr_q;
  logic                 rw_q;
  scs_pkg::scs_phase_t  phase_q;
  scs_pkg::scs_phase_t  phase_d;
  scs_pkg::scs_word_t   tx_q;
  scs_pkg::scs_word_t   tx_d;
  scs_pkg::scs_word_t   cfg_q;
  logic                 pin_q;

  scs_mem_if mem_port ();

  scs_regbank u_regbank (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .port      (mem_port)
  );

  // every pin goes through two flops; the first stage feeds only the second
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta_q <= 20'h00002;
      pin_sync_q <= 20'h00002;
    end else begin
      pin_meta_q <= {lock_status_in, live_status_in, serial_in_pin_in, cs_pin_n_in,
                     sclk_pin_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire                     sclk_s = pin_sync_q[0];
  wire                     cs_n_s = pin_sync_q[1];
  wire                     sdi_s  = pin_sync_q[2];
  // status bits are synchronised one by one and may skew by a cycle
  wire scs_pkg::scs_word_t live_s = pin_sync_q[18:3];
  wire                     lock_s = pin_sync_q[19];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  // clock edges only count while selected
  wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  wire cs_rise   = cs_n_s & ~cs_n_prev_q;

  // bit counter saturates so an overlong frame never looks complete
  assign bit_cnt_d = cs_n_s ? 5'h00 :
                     (sclk_rise && bit_cnt_q != `SCS_CNT_MAX) ? bit_cnt_q + 5'h01 :
                     bit_cnt_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shift_q <= 24'h000000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[22:0], sdi_s};
    end
  end

  // eighth bit completes the header: flag then 7-bit address
  wire                   head_done = sclk_rise && (bit_cnt_q == `SCS_HEAD_LAST);
  wire scs_pkg::scs_addr_t head_addr = {shift_q[5:0], sdi_s};

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= 7'h00;
      rw_q   <= 1'b0;
    end else if (head_done) begin
      addr_q <= head_addr;
      rw_q   <= shift_q[6];
    end
  end

  // the store is read as soon as the address is known, well ahead of the data part
  assign mem_port.rd_en   = head_done;
  assign mem_port.rd_addr = head_addr;

  wire is_cfg    = (addr_q == `SCS_CFG_ADDR);
  wire is_status = (addr_q == `SCS_STATUS_ADDR);

  // config and status answer from live logic, not from a copy of the last write
  wire scs_pkg::scs_word_t rd_value = is_cfg    ? cfg_q :
                                      is_status ? live_s :
                                      mem_port.rd_data;

  // a write needs exactly 24 bits and a zero flag; reads never reach the stores
  wire wr_go = cs_rise && (bit_cnt_q == `SCS_FRAME_BITS) && !rw_q;

  assign mem_port.wr_en   = wr_go && !is_cfg && !is_status;
  assign mem_port.wr_addr = addr_q;
  assign mem_port.wr_data = shift_q[15:0];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_q <= `SCS_CFG_RESET;
    end else if (wr_go && is_cfg) begin
      cfg_q <= shift_q[15:0];
    end
  end

  wire read_load = sclk_fall && (phase_q == scs_pkg::PH_HEAD) && rw_q &&
                   (bit_cnt_q == `SCS_HEAD_BITS);

  always_comb begin
    phase_d = phase_q;
    tx_d    = tx_q;
    unique case (phase_q)
      scs_pkg::PH_IDLE: begin
        if (!cs_n_s) begin
          phase_d = scs_pkg::PH_HEAD;
          tx_d    = 16'h0000;
        end
      end
      scs_pkg::PH_HEAD: begin
        if (cs_n_s) begin
          phase_d = scs_pkg::PH_IDLE;
        end else if (read_load) begin
          phase_d = scs_pkg::PH_READ;
          tx_d    = rd_value;
        end
      end
      scs_pkg::PH_READ: begin
        // input data is not looked at here
        if (cs_n_s) begin
          phase_d = scs_pkg::PH_IDLE;
        end else if (sclk_fall && bit_cnt_q < `SCS_FRAME_BITS) begin
          // the fall after the last rise is not a data edge: shifting there would
          // replace the last bit with zero on the still driven pin
          tx_d = {tx_q[14:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_q <= scs_pkg::PH_IDLE;
      tx_q    <= 16'h0000;
    end else begin
      phase_q <= phase_d;
      tx_q    <= tx_d;
    end
  end

  // last bit stays on the pin after the frame; only the enable releases it
  wire lock_sel = cfg_q[`SCS_CFG_LOCK_BIT];
  wire pin_d    = lock_sel ? lock_s : tx_q[15];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign readback_mux_pin_out    = pin_q;
  assign readback_mux_pin_oe_out = cfg_q[`SCS_CFG_EN_BIT];
  assign cfg_word_out            = cfg_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_read_load;
    read_load;
  endsequence

  sequence s_status_load;
    read_load && is_status;
  endsequence

  chk_shift_on_rise: assert property (
    sclk_rise |=> shift_q[0] == $past(sdi_s) && shift_q[23:1] == $past(shift_q[22:0]))
    else $error("input bit not shifted on rising clock");

  chk_deselect_ignore: assert property (
    cs_n_s |=> bit_cnt_q == 5'h00 && $stable(shift_q))
    else $error("clock counted while deselected");

  chk_addr_part_low: assert property (
    (phase_q == scs_pkg::PH_HEAD && !lock_sel) ##1 !lock_sel |-> readback_mux_pin_out == 1'b0)
    else $error("readback pin not low in address part");

  chk_fall_shift: assert property (
    (phase_q == scs_pkg::PH_READ && sclk_fall && !cs_n_s) |=>
      tx_q == (($past(bit_cnt_q) < `SCS_FRAME_BITS) ? {$past(tx_q[14:0]), 1'b0} : $past(tx_q)))
    else $error("readback bit not advanced on falling clock");

  chk_read_no_write: assert property (
    rw_q && cs_rise |-> !mem_port.wr_en ##1 $stable(cfg_q))
    else $error("read frame changed a register");

  chk_drive_follows_en: assert property (
    !(wr_go && is_cfg) |=> $stable(readback_mux_pin_oe_out))
    else $error("pin drive changed without enable write");

  chk_live_status: assert property (
    s_status_load |=> tx_q == $past(live_s))
    else $error("status read not taken from live state");

  chk_load_value: assert property (
    s_read_load |=> phase_q == scs_pkg::PH_READ ##1 (lock_sel || readback_mux_pin_out == tx_q[15] ||
                    $changed(tx_q)))
    else $error("read data not loaded at data part");

  chk_lock_mux: assert property (
    lock_sel |=> readback_mux_pin_out == $past(lock_s))
    else $error("lock status not shown on readback pin");

  chk_cfg_commit: assert property (
    (wr_go && is_cfg) |=> cfg_q == $past(shift_q[15:0]))
    else $error("config write not committed at select rise");
endmodule
`default_nettype wire

// >>> logic/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// frame layout: flag, 7-bit address, 16 data bits, msb first
`define SCS_FRAME_BITS   5'h18
`define SCS_HEAD_BITS    5'h08
`define SCS_HEAD_LAST    5'h07
`define SCS_CNT_MAX      5'h1F
`define SCS_ADDR_W       7
`define SCS_DATA_W       16
`define SCS_MEM_DEPTH    128

// addresses served by live logic rather than the register store
`define SCS_CFG_ADDR     7'h7E
`define SCS_STATUS_ADDR  7'h7F

// configuration word fields and reset value
`define SCS_CFG_EN_BIT   0
`define SCS_CFG_LOCK_BIT 1
`define SCS_CFG_RESET    16'h0001

`endif

// >>> logic/scs_pkg.sv
`default_nettype none
package scs_pkg;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HEAD,
    PH_READ
  } scs_phase_t;

  typedef logic [6:0]  scs_addr_t;
  typedef logic [15:0] scs_word_t;
endpackage
`default_nettype wire

// >>> logic/scs_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scs_mem_if;
  logic              wr_en;
  scs_pkg::scs_addr_t wr_addr;
  scs_pkg::scs_word_t wr_data;
  logic              rd_en;
  scs_pkg::scs_addr_t rd_addr;
  scs_pkg::scs_word_t rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> logic/scs_regbank.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module scs_regbank (
  input  wire logic mclk_in,   // system clock
  input  wire logic resetn_in, // async reset, active low
  scs_mem_if.mem    port       // write and registered read port
);
  scs_pkg::scs_word_t mem_q [`SCS_MEM_DEPTH];
  scs_pkg::scs_word_t rd_q;

  // cleared at reset so a read before any write returns zero, not unknowns
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `SCS_MEM_DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_q <= 16'h0000;
    end else if (port.rd_en) begin
      rd_q <= mem_q[port.rd_addr];
    end
  end

  assign port.rd_data = rd_q;
endmodule
`default_nettype wire

// >>> tb/scs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
  input  wire logic mclk_in,  // bench clock, paces the serial link
  input  wire logic rb_in,    // readback pin from the device
  output logic      sclk_out, // serial clock, low outside frames except during stray pulses
  output logic      cs_n_out, // select, active low
  output logic      sdi_out   // serial data to the device
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // half of a 160 ns serial period
  task automatic phase();
    repeat (4) @(negedge mclk_in);
  endtask

  // flag, address, data sent msb first; nbits below 24 makes a short frame
  task automatic xfer(input logic [23:0] frm, input int nbits,
                      output logic [15:0] rd, output logic addr_hi);
    rd = 16'h0000;
    addr_hi = 1'b0;
    @(negedge mclk_in);
    cs_n_out = 1'b0; // held low for the whole frame
    for (int i = 0; i < nbits; i++) begin
      sdi_out = frm[23-i];
      phase();
      sclk_out = 1'b1; // idle low, data stable before the rise
      phase();
      // sampled late in the phase, long after the previous fall
      if (i < 8) addr_hi = addr_hi | rb_in;
      else rd[23-i] = rb_in;
      sclk_out = 1'b0;
    end
    phase();
    cs_n_out = 1'b1; // deselected between frames
    sdi_out = ~sdi_out; // released line does not keep its last level
    phase();
    phase();
  endtask

  // clock pulses while deselected, as when another device is addressed
  task automatic stray();
    for (int i = 0; i < 24; i++) begin
      sdi_out = ~i[0];
      phase();
      sclk_out = 1'b1;
      phase();
      sclk_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/test_spi_config_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_spi_config_slave_port;
  logic        mclk, resetn, sclk, cs_n, serial_in_pin, lock, rb, oe, ah;
  logic [15:0] live, cfg, rd;
  int          error_cnt, comparisons;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  scs_top DUT (
    .mclk_in(mclk), .resetn_in(resetn), .sclk_pin_in(sclk), .cs_pin_n_in(cs_n),
    .serial_in_pin_in(serial_in_pin), .lock_status_in(lock), .live_status_in(live),
    .readback_mux_pin_out(rb), .readback_mux_pin_oe_out(oe), .cfg_word_out(cfg)
  );
  scs_host_model host (
    .mclk_in(mclk), .rb_in(rb), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(serial_in_pin)
  );

  task automatic report_and_stop();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [15:0] junk);
    host.xfer({1'b1, a, junk}, 24, rd, ah);
    `CHK(ah, 1'b0)
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [15:0] d, input int n);
    host.xfer({1'b0, a, d}, n, rd, ah);
  endtask

  task automatic t_reset();
    `CHK(rb, 1'b0)
    `CHK(oe, 1'b1)
    `CHK(cfg, 16'h0001)
  endtask

  task automatic t_store();
    write_reg(7'h05, 16'hA5C3, 24);
    write_reg(7'h06, 16'h5A3C, 24);
    read_reg(7'h05, 16'hFFFF);
    `CHK(rd, 16'hA5C3)
    `CHK(rb, 1'b1)
    read_reg(7'h06, 16'h0000);
    `CHK(rd, 16'h5A3C)
    `CHK(oe, 1'b1)
  endtask

  task automatic t_refused();
    write_reg(7'h05, 16'h1234, 23);
    read_reg(7'h05, 16'h0F0F);
    `CHK(rd, 16'hA5C3)
    host.stray();
    read_reg(7'h06, 16'hFFFF);
    `CHK(rd, 16'h5A3C)
  endtask

  task automatic t_live();
    live = 16'h3C5A;
    read_reg(7'h7F, 16'h0000);
    `CHK(rd, 16'h3C5A)
    write_reg(7'h7F, 16'h0000, 24);
    @(negedge mclk);
    live = 16'hC3A5;
    read_reg(7'h7F, 16'h0000);
    `CHK(rd, 16'hC3A5)
    read_reg(7'h7E, 16'h0000);
    `CHK(rd, 16'h0001)
  endtask

  task automatic t_mux();
    write_reg(7'h7E, 16'h0003, 24);
    `CHK(cfg, 16'h0003)
    lock = 1'b1;
    repeat (8) @(negedge mclk);
    `CHK(rb, 1'b1)
    lock = 1'b0;
    repeat (8) @(negedge mclk);
    `CHK(rb, 1'b0)
    write_reg(7'h7E, 16'h0000, 24); // host releases the pin when done
    `CHK(oe, 1'b0)
    `CHK(cfg, 16'h0000)
  endtask

  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    error_cnt = 0;
    comparisons = 0;
    resetn = 1'b0;
    lock = 1'b0;
    live = 16'h0000;
    repeat (6) @(negedge mclk);
    t_reset();
    resetn = 1'b1;
    repeat (6) @(negedge mclk);
    t_store();
    t_refused();
    t_live();
    t_mux();
    report_and_stop();
  end
endmodule
`default_nettype wire
